// ---- core/eccp_pkg.sv ----
// Shared constants and types for the enhanced capture/compare/PWM mode control
package eccp_pkg;

    // ****
    // Register map (byte addresses)
    // ****
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_DUTY = 6'h04;
    localparam logic [5:0] OFS_CMP1 = 6'h08;
    localparam logic [5:0] OFS_CAPT = 6'h0C;
    localparam logic [5:0] OFS_STAT = 6'h10;
    localparam logic [5:0] OFS_CFG = 6'h14;
    localparam logic [5:0] OFS_T3CNT = 6'h18;
    localparam logic [5:0] OFS_CMP2 = 6'h1C;
    localparam logic [5:0] OFS_PER = 6'h20;
    localparam logic [5:0] OFS_STEER = 6'h24;

    // ****
    // Values after reset and bus answers
    // ****
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****
    // Mode codes and output configurations
    // ****
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TGL = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4 = 4'h6;
    localparam logic [3:0] MODE_CAP_16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] MODE_CMP_SWI = 4'hA;
    localparam logic [3:0] MODE_CMP_SEVT = 4'hB;
    localparam logic [1:0] PWM_GROUP = 2'h3;
    localparam logic [1:0] OCFG_SINGLE = 2'h0;
    localparam logic [1:0] OCFG_FWD = 2'h1;
    localparam logic [1:0] OCFG_HALF = 2'h2;
    localparam logic [1:0] OCFG_REV = 2'h3;
    localparam logic [3:0] CAP_LAST_4 = 4'h3;
    localparam logic [3:0] CAP_LAST_16 = 4'hF;
    localparam logic [1:0] PWM_Q_LAST = 2'h3;

    // ****
    // Types
    // ****
    typedef struct packed {
        logic [1:0] output_config;
        logic [1:0] duty_low_bits;
        logic [3:0] unit_mode_sel;
    } ctrl_t;

    // Bit 0 is output A, bit 3 output D; own high means the unit drives the pin
    typedef struct packed {
        logic [3:0] drive;
        logic [3:0] own;
    } pins_t;

endpackage : eccp_pkg

// ---- core/sevt_timer.sv ----
// Sixteen-bit timer with software load and special-event clear
`timescale 1ns/1ps
module sevt_timer #(
    parameter int WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic async_mode,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic sevt_clr,
    output logic [WIDTH-1:0] count,
    output logic wrap
);
    import eccp_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic wrap;
    } tmr_st_t;

    tmr_st_t s_r;
    tmr_st_t s_nxt;

    // Load beats clear; no clear in async mode; wrap on overflow only
    always_comb begin
        s_nxt = s_r;
        s_nxt.wrap = 1'b0;
        if (load) begin
            s_nxt.count = load_value;
        end else if (sevt_clr && !async_mode) begin
            s_nxt.count = '0;
        end else if (run) begin
            s_nxt.count = s_r.count + 1'b1;
            s_nxt.wrap = &s_r.count;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r.count;
    assign wrap = s_r.wrap;

endmodule : sevt_timer

// ---- core/pwm_pin_map.sv ----
// Output configuration and polarity mapping onto the four drive pins
`timescale 1ns/1ps
module pwm_pin_map (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pwm_mode,
    input wire logic [1:0] ocfg,
    input wire logic [1:0] pol,
    input wire logic pwm,
    input wire logic [3:0] steer,
    input wire logic cmp_drive,
    input wire logic cmp_own,
    output eccp_pkg::pins_t pins
);
    import eccp_pkg::*;

    typedef struct packed {
        pins_t pins;
    } map_st_t;

    map_st_t s_r;
    map_st_t s_nxt;
    logic [3:0] act;
    logic [3:0] inv;

    // Pick active levels per configuration, then apply pair polarity
    always_comb begin
        s_nxt = s_r;
        act = 4'h0;
        inv = {pol[0], pol[1], pol[0], pol[1]};
        if (pwm_mode) begin
            unique case (ocfg)
                OCFG_SINGLE: begin
                    act = {4{pwm}};
                    s_nxt.pins.own = steer;
                end
                OCFG_FWD: begin
                    act = {pwm, 1'b0, 1'b0, 1'b1};
                    s_nxt.pins.own = 4'hF;
                end
                OCFG_HALF: begin
                    act = {2'b00, ~pwm, pwm};
                    s_nxt.pins.own = 4'h3;
                end
                OCFG_REV: begin
                    act = {1'b0, 1'b1, pwm, 1'b0};
                    s_nxt.pins.own = 4'hF;
                end
            endcase
            s_nxt.pins.drive = act ^ inv;
        end else begin
            s_nxt.pins.drive = {3'b000, cmp_drive};
            s_nxt.pins.own = {3'b000, cmp_own};
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pins = s_r.pins;

endmodule : pwm_pin_map

// ---- core/eccp_mode_ctrl.sv ----
// Enhanced capture/compare/PWM mode control with AXI4-Lite registers
//
// Behaviour
// - Unit on Timer3 in special-event compare mode resets Timer3 on match.
// - A special event also starts a conversion when the converter is enabled.
// - No special-event reset while Timer3 counts asynchronously.
// - A same-cycle timer write beats the special-event reset.
// - Special-event resets never set the Timer3 overflow flag.
// - Second unit's compare pair sets the Timer3 period.
// - Outside PWM: config ignored, A is compare pin, B-D port pins.
// - Config 00 single output, steered; 01 forward bridge, D modulated.
// - Config 10 half bridge: A and B modulated, C and D port pins.
// - Config 11 reverse bridge: B modulated, C active, A and D inactive.
// - Control bits 5:4 are the duty low bits.
// - Mode 0000 turns the unit off and resets it; 0001 and 0011 reserved.
// - Mode 0010 toggles the compare pin on each match.
// - Capture on falling, rising, every 4th or every 16th rising edge.
// - Modes 1000/1001 start pin low/high, drive high/low on match, set flag.
// - Mode 1010 only sets the flag on match; pin left to the port.
// - Mode 1011 resets the selected timer on match and sets the flag.
// - PWM modes 11xx; bit 1 inverts A and C, bit 0 inverts B and D.
// - All eight control bits read and write, and reset to zero.
// - Timer select: 1x Timer3 both, 01 Timer3 second unit, 00 Timer1.
`timescale 1ns/1ps
module eccp_mode_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [eccp_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [eccp_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic cap_pin,
    input wire logic adc_enabled,
    input wire logic [15:0] timer1_count,
    output logic timer1_clear,
    output logic adc_start,
    output eccp_pkg::pins_t pins
);
    import eccp_pkg::*;

    // ****
    // State
    // ****
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        ctrl_t ctrl;
        logic [7:0] duty_high;
        logic [15:0] cmp1;
        logic [15:0] capt;
        logic match_flag;
        logic ovf_flag;
        logic [1:0] tsel;
        logic [3:0] mode2;
        logic t3_on;
        logic t3_async;
        logic [15:0] cmp2;
        logic [7:0] period;
        logic [3:0] steer;
        logic cap_prev;
        logic [3:0] cap_cnt;
        logic eq1_prev;
        logic eq2_prev;
        logic cmp_pin;
        logic [7:0] pwm_cnt;
        logic [1:0] pwm_q;
        logic [9:0] duty_act;
        logic [1:0] ocfg_act;
        logic pwm_run;
        logic pwm;
        logic timer1_clear;
        logic adc_start;
    } st_t;

    st_t s_r;
    st_t s_nxt;

    logic wr_go;
    logic ar_go;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;
    logic [3:0] mode;
    logic pwm_mode;
    logic [15:0] t3_count;
    logic t3_wrap;
    logic t3_load;
    logic [15:0] t3_load_val;
    logic sevt3;
    logic [15:0] sel1;
    logic eq1;
    logic eq2;
    logic match1;
    logic match2;
    logic rise;
    logic fall;
    logic cap_evt;
    logic cmp_mode;
    logic cmp_own;
    logic sevt1;
    logic sevt2;
    logic pwm_end;
    logic flag_set;

    // Merge byte lanes 0 and 1 into a 16-bit field
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : merge16

    // ****
    // Decode and event terms
    // ****

    // Bus handshakes and address decode
    assign wr_go = s_r.awready && awvalid && s_r.wready && wvalid;
    assign ar_go = s_r.arready && arvalid;
    assign mode = s_r.ctrl.unit_mode_sel;
    assign pwm_mode = mode[3:2] == PWM_GROUP;
    assign t3_load = wr_go && awaddr == OFS_T3CNT && (wstrb[0] || wstrb[1]);
    assign t3_load_val = merge16(t3_count, wdata, wstrb);

    // Time base for this unit: Timer3 only when select is 1x
    assign sel1 = s_r.tsel[1] ? t3_count : timer1_count;

    // One match per arrival at the compare value
    assign eq1 = sel1 == s_r.cmp1;
    assign eq2 = t3_count == s_r.cmp2;
    assign match1 = eq1 && !s_r.eq1_prev;
    assign match2 = eq2 && !s_r.eq2_prev;

    // Capture edges and prescale
    assign rise = cap_pin && !s_r.cap_prev;
    assign fall = !cap_pin && s_r.cap_prev;
    always_comb begin
        cap_evt = 1'b0;
        unique case (mode)
            MODE_CAP_FALL: cap_evt = fall;
            MODE_CAP_RISE: cap_evt = rise;
            MODE_CAP_4: cap_evt = rise && s_r.cap_cnt[1:0] == CAP_LAST_4[1:0];
            MODE_CAP_16: cap_evt = rise && s_r.cap_cnt == CAP_LAST_16;
            default: cap_evt = 1'b0;
        endcase
    end

    // Compare group and who owns output A
    assign cmp_mode = mode == MODE_CMP_TGL || mode[3:2] == 2'b10;
    assign cmp_own = mode == MODE_CMP_TGL || mode == MODE_CMP_SET || mode == MODE_CMP_CLR;

    // Special events of both units
    assign sevt1 = mode == MODE_CMP_SEVT && match1;
    assign sevt2 = s_r.mode2 == MODE_CMP_SEVT && s_r.tsel != 2'b00 && match2;
    assign sevt3 = (sevt1 && s_r.tsel[1]) || sevt2;
    assign flag_set = cap_evt || (cmp_mode && match1);

    // PWM period end: eight-bit count reaches period and last quarter
    assign pwm_end = s_r.pwm_cnt == s_r.period && s_r.pwm_q == PWM_Q_LAST;

    // Write hit: aligned word inside the map
    assign wr_hit = awaddr[1:0] == 2'b00 && awaddr <= OFS_STEER;

    // Reads decode the same map
    assign rd_hit = araddr[1:0] == 2'b00 && araddr <= OFS_STEER;

    // Read data mux
    always_comb begin
        rd_word = '0;
        unique case (araddr)
            OFS_CTRL: rd_word = 32'(s_r.ctrl);
            OFS_DUTY: rd_word = 32'(s_r.duty_high);
            OFS_CMP1: rd_word = 32'(s_r.cmp1);
            OFS_CAPT: rd_word = 32'(s_r.capt);
            OFS_STAT: rd_word = 32'({s_r.pwm_run, s_r.cmp_pin, s_r.ovf_flag, s_r.match_flag});
            OFS_CFG: rd_word = 32'({s_r.t3_async, s_r.t3_on, s_r.mode2, s_r.tsel});
            OFS_T3CNT: rd_word = 32'(t3_count);
            OFS_CMP2: rd_word = 32'(s_r.cmp2);
            OFS_PER: rd_word = 32'(s_r.period);
            OFS_STEER: rd_word = 32'(s_r.steer);
            default: rd_word = '0;
        endcase
    end

    // ****
    // Next state
    // ****
    always_comb begin
        s_nxt = s_r;

        // Write channel: take address and data together, then answer
        if (!s_r.awready && !s_r.bvalid && awvalid && wvalid) begin
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
        end else if (wr_go) begin
            s_nxt.awready = 1'b0;
            s_nxt.wready = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Read channel
        if (!s_r.arready && !s_r.rvalid && arvalid) begin
            s_nxt.arready = 1'b1;
        end else if (ar_go) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_word;
            s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // Edge and match history
        s_nxt.cap_prev = cap_pin;
        s_nxt.eq1_prev = eq1;
        s_nxt.eq2_prev = eq2;
        s_nxt.timer1_clear = sevt1 && !s_r.tsel[1];
        s_nxt.adc_start = (sevt1 || sevt2) && adc_enabled;

        // Capture prescale counter and captured value
        if (rise) begin
            s_nxt.cap_cnt = s_r.cap_cnt + 4'h1;
        end
        if (cap_evt) begin
            s_nxt.capt = sel1;
        end

        // Compare pin actions
        if (match1) begin
            unique case (mode)
                MODE_CMP_TGL: s_nxt.cmp_pin = !s_r.cmp_pin;
                MODE_CMP_SET: s_nxt.cmp_pin = 1'b1;
                MODE_CMP_CLR: s_nxt.cmp_pin = 1'b0;
                default: s_nxt.cmp_pin = s_r.cmp_pin;
            endcase
        end

        // Flags: hardware set wins over a clear in the same cycle
        if (wr_go && awaddr == OFS_STAT && wstrb[0]) begin
            s_nxt.match_flag = s_r.match_flag && !wdata[0];
            s_nxt.ovf_flag = s_r.ovf_flag && !wdata[1];
        end
        if (flag_set) begin
            s_nxt.match_flag = 1'b1;
        end
        if (t3_wrap) begin
            s_nxt.ovf_flag = 1'b1;
        end

        // PWM time base; output starts only at a fresh period
        if (pwm_mode) begin
            if (pwm_end) begin
                s_nxt.pwm_cnt = 8'h00;
                s_nxt.pwm_q = 2'h0;
                s_nxt.duty_act = {s_r.duty_high, s_r.ctrl.duty_low_bits};
                s_nxt.ocfg_act = s_r.ctrl.output_config;
                s_nxt.pwm_run = 1'b1;
            end else begin
                {s_nxt.pwm_cnt, s_nxt.pwm_q} = {s_r.pwm_cnt, s_r.pwm_q} + 10'h001;
            end
            s_nxt.pwm = s_r.pwm_run && {s_r.pwm_cnt, s_r.pwm_q} < s_r.duty_act;
        end else begin
            s_nxt.pwm_cnt = 8'h00;
            s_nxt.pwm_q = 2'h0;
            s_nxt.pwm_run = 1'b0;
            s_nxt.pwm = 1'b0;
        end

        // Register writes
        if (wr_go && wstrb[0]) begin
            unique case (awaddr)
                OFS_CTRL: begin
                    s_nxt.ctrl = wdata[7:0];
                    if (wdata[3:0] == MODE_CMP_SET) begin
                        s_nxt.cmp_pin = 1'b0;
                    end else if (wdata[3:0] == MODE_CMP_CLR) begin
                        s_nxt.cmp_pin = 1'b1;
                    end
                end
                OFS_DUTY: s_nxt.duty_high = wdata[7:0];
                OFS_CFG: begin
                    s_nxt.tsel = wdata[1:0];
                    s_nxt.mode2 = wdata[5:2];
                    s_nxt.t3_on = wdata[6];
                    s_nxt.t3_async = wdata[7];
                end
                OFS_PER: s_nxt.period = wdata[7:0];
                OFS_STEER: s_nxt.steer = wdata[3:0];
                default: ;
            endcase
        end
        if (wr_go && awaddr == OFS_CMP1) begin
            s_nxt.cmp1 = merge16(s_r.cmp1, wdata, wstrb);
        end
        if (wr_go && awaddr == OFS_CMP2) begin
            s_nxt.cmp2 = merge16(s_r.cmp2, wdata, wstrb);
        end

        // Off mode holds the unit in reset
        if (s_nxt.ctrl.unit_mode_sel == MODE_OFF) begin
            s_nxt.cap_cnt = 4'h0;
            s_nxt.cmp_pin = 1'b0;
            s_nxt.pwm_run = 1'b0;
            s_nxt.pwm = 1'b0;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****
    // Timer3 and pin mapping
    // ****
    sevt_timer #(
        .WIDTH(16)
    ) u_timer3 (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(s_r.t3_on),
        .async_mode(s_r.t3_async),
        .load(t3_load),
        .load_value(t3_load_val),
        .sevt_clr(sevt3),
        .count(t3_count),
        .wrap(t3_wrap)
    );

    pwm_pin_map u_pin_map (
        .aclk(aclk),
        .aresetn(aresetn),
        .pwm_mode(pwm_mode),
        .ocfg(s_r.ocfg_act),
        .pol(mode[1:0]),
        .pwm(s_r.pwm),
        .steer(s_r.steer),
        .cmp_drive(s_r.cmp_pin),
        .cmp_own(cmp_own),
        .pins(pins)
    );

    // Outputs straight from flip-flops
    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rresp = s_r.rresp;
    assign rdata = s_r.rdata;
    assign timer1_clear = s_r.timer1_clear;
    assign adc_start = s_r.adc_start;

endmodule : eccp_mode_ctrl

// ---- verif/eccp_assertions.sv ----
// Port checker for the mode control block
`timescale 1ns/1ps
module eccp_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic adc_enabled,
    input wire logic adc_start,
    input wire logic timer1_clear,
    input wire eccp_pkg::pins_t pins
);
    import eccp_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****
    // Bus handshake
    // ****
    aw_w_pair_a: assert property (awready == wready && (awready -> awvalid && wvalid))
        else $error("aw and w apart");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("b dropped");
    read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("r dropped");
    write_resp_a: assert property ($rose(bvalid) |-> $past(awready && awvalid))
        else $error("stray b");
    read_resp_a: assert property ($rose(rvalid) |-> $past(arready))
        else $error("stray r");
    bresp_code_a: assert property (bvalid |-> bresp == RESP_OKAY || bresp == RESP_SLVERR)
        else $error("bad bresp");
    // ****
    // Special events
    // ****
    adc_pulse_a: assert property (adc_start |-> $past(adc_enabled) ##1 !adc_start)
        else $error("bad adc pulse");
    clear_adc_a: assert property (timer1_clear && $past(adc_enabled) |-> adc_start)
        else $error("clear without adc");
    reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> pins == '0 && !bvalid && !adc_start)
        else $error("reset outputs");
    cover property (adc_start);
    cover property (timer1_clear);
    cover property ($rose(rvalid) && rdata != 32'h0);
endmodule : eccp_checker

// ---- verif/bridge_driver_model.sv ----
// Power switch driver model on the four bridge outputs
`timescale 1ns/1ps
module bridge_driver_model (
    input wire logic aclk,
    input wire logic clr,
    input wire eccp_pkg::pins_t pins,
    output logic [3:0] gate,
    output int on_a
);
    import eccp_pkg::*;
    // Port latches stay low, so an unowned pin leaves its switch off
    assign gate = pins.drive & pins.own;
    // Active cycles seen by the leg A switch
    always @(posedge aclk) begin
        on_a <= clr ? 0 : on_a + int'(gate[0]);
    end
endmodule : bridge_driver_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the mode control block
`timescale 1ns/1ps
module tb_top;
    import eccp_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic cap_pin = 0, adc_enabled = 0, cnt_rst = 0, awready, wready, bvalid, arready, rvalid;
    logic timer1_clear, adc_start;
    logic [5:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic [15:0] timer1_count = 0;
    pins_t pins;
    int n_fail = 0, checks = 0, adc_n = 0, clr_n = 0, on_a, mreg[int];
    logic [3:0] cmp_modes[4] = '{MODE_CMP_TGL, MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_SWI};
    int cap_n[4] = '{1, 1, 4, 16};

    eccp_mode_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cap_pin(cap_pin), .adc_enabled(adc_enabled), .timer1_count(timer1_count),
        .timer1_clear(timer1_clear), .adc_start(adc_start), .pins(pins));
    bridge_driver_model i_drv (.aclk(aclk), .clr(cnt_rst), .pins(pins), .gate(), .on_a(on_a));

    always #25 aclk = ~aclk;
    // Event pulse counters
    always @(posedge aclk) begin
        adc_n <= cnt_rst ? 0 : adc_n + int'(adc_start);
        clr_n <= cnt_rst ? 0 : clr_n + int'(timer1_clear);
    end

    function automatic logic [31:0] msk(input logic [5:0] a);
        case (a)
            OFS_CMP1, OFS_T3CNT, OFS_CMP2: return 32'hFFFF;
            OFS_CTRL, OFS_DUTY, OFS_CFG, OFS_PER: return 32'hFF;
            OFS_STEER, OFS_STAT, OFS_CAPT: return 32'hF;
            default: return 32'h0;
        endcase
    endfunction : msk

    // PWM pins at zero duty
    function automatic logic [7:0] pin_exp(input logic [1:0] oc, input logic [1:0] pol);
        logic [3:0] own, drv;
        own = (oc == OCFG_HALF) ? 4'h3 : 4'hF;
        drv = (oc == OCFG_FWD) ? 4'h1 : (oc == OCFG_REV) ? 4'h4 : (oc == OCFG_HALF) ? 4'h2 : 4'h0;
        return {(drv ^ {pol[0], pol[1], pol[0], pol[1]}) & own, own};
    endfunction : pin_exp

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pins(input logic [7:0] exp);
        chk_reg(32'({pins.drive & pins.own, pins.own}), 32'(exp));
    endtask : chk_pins

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        if (a != OFS_STAT && a != OFS_T3CNT) mreg[a] = d & msk(a);
        chk_reg(32'(bresp), (msk(a) != 0) ? RESP_OKAY : RESP_SLVERR);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk_reg(32'(rresp), (msk(a) != 0) ? RESP_OKAY : RESP_SLVERR);
    endtask : rd

    task automatic zero_counts();
        cnt_rst <= 1'b1;
        @(posedge aclk);
        cnt_rst <= 1'b0;
    endtask : zero_counts

    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        finish_test();
    end

    // ****
    // Main sequence
    // ****
    initial begin
        logic [31:0] v;
        logic [15:0] c;
        v = $urandom(29);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk_pins(8'h00);
        rd(OFS_CTRL, v);
        chk_reg(v, 32'(CTRL_RST));
        wr(OFS_CTRL, $urandom_range(0, 255));
        rd(OFS_CTRL, v);
        chk_reg(v, mreg[OFS_CTRL]);
        rd(6'h3C, v);
        chk_reg(v, 32'h0);
        // Compare modes; config ignored
        c = 16'($urandom_range(1, 16'hFFFE));
        wr(OFS_CMP1, 32'(c));
        foreach (cmp_modes[i]) begin
            wr(OFS_CTRL, 32'h0);
            wr(OFS_STAT, 32'h3);
            wr(OFS_CTRL, 32'({4'hC, cmp_modes[i]}));
            repeat (3) @(posedge aclk);
            chk_pins({3'b0, cmp_modes[i] == MODE_CMP_CLR, 3'b0, cmp_modes[i] != MODE_CMP_SWI});
            timer1_count <= c;
            repeat (3) @(posedge aclk);
            chk_pins({3'b0, cmp_modes[i] < MODE_CMP_CLR, 3'b0, cmp_modes[i] != MODE_CMP_SWI});
            rd(OFS_STAT, v);
            chk_reg(32'(v[0]), 32'h1);
            timer1_count <= 16'h0;
        end
        // Capture prescale
        foreach (cap_n[i]) begin
            wr(OFS_CTRL, 32'h0);
            wr(OFS_CTRL, 32'(MODE_CAP_FALL) + i);
            for (int e = 1; e < 2 * cap_n[i]; e++) begin
                timer1_count <= 16'(e * 16 + i);
                cap_pin <= 1'b1;
                repeat (3) @(posedge aclk);
                cap_pin <= 1'b0;
                repeat (3) @(posedge aclk);
            end
            rd(OFS_CAPT, v);
            chk_reg(v, 32'(cap_n[i] * 16 + i));
        end
        // Special event on Timer1
        wr(OFS_CTRL, 32'(MODE_CMP_SEVT));
        adc_enabled <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            wr(OFS_CFG, s);
            zero_counts();
            timer1_count <= c;
            repeat (4) @(posedge aclk);
            timer1_count <= 16'h0;
            chk_reg(32'(clr_n), 32'(s < 2));
            chk_reg(32'(adc_n), 32'(s < 2));
        end
        // Second unit sets Timer3 period
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CMP2, 32'h10);
        wr(OFS_CFG, 32'h6E);
        for (int g = 1; g >= 0; g--) begin
            adc_enabled <= g[0];
            zero_counts();
            repeat (171) @(posedge aclk);
            chk_reg(32'(adc_n), 32'(10 * g));
        end
        rd(OFS_T3CNT, v);
        chk_reg(32'(v <= 32'h10), 32'h1);
        rd(OFS_STAT, v);
        chk_reg(32'(v[1]), 32'h0);
        wr(OFS_CFG, 32'hEE);
        repeat (40) @(posedge aclk);
        rd(OFS_T3CNT, v);
        chk_reg(32'(v > 32'h10), 32'h1);
        wr(OFS_CFG, 32'h0);
        // Duty and polarity
        wr(OFS_PER, 32'h9);
        wr(OFS_DUTY, 32'h2);
        wr(OFS_STEER, 32'h1);
        for (int p = 0; p < 2; p++) begin
            wr(OFS_CTRL, 32'h3C | (p << 1));
            repeat (100) @(posedge aclk);
            zero_counts();
            repeat (201) @(posedge aclk);
            chk_reg(32'(on_a), p ? 32'd145 : 32'd55);
        end
        // Configs by polarity
        wr(OFS_DUTY, 32'h0);
        wr(OFS_STEER, 32'hF);
        for (int k = 0; k < 16; k++) begin
            wr(OFS_CTRL, {24'h0, k[3:2], 4'h3, k[1:0]});
            repeat (100) @(posedge aclk);
            chk_pins(pin_exp(k[3:2], k[1:0]));
        end
        wr(OFS_CTRL, 32'h0);
        repeat (3) @(posedge aclk);
        chk_pins(8'h00);
        finish_test();
    end
endmodule : tb_top

bind eccp_mode_ctrl eccp_checker i_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .adc_enabled(adc_enabled), .adc_start(adc_start), .timer1_clear(timer1_clear), .pins(pins));
